// ===== sim/hlc_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module hlc_fetch_model
	import hlc_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Bench control
	input  wire logic            go,
	input  wire logic [AW_W-1:0] start_pc,
	// Fetch stage
	output logic                 fetch_valid,
	output logic      [AW_W-1:0] fetch_pc,
	input  wire logic            branch_valid,
	input  wire logic [AW_W-1:0] branch_addr
);
	// Fetch on alternate cycles so a reload lands before the next fetch
	logic            phase;
	logic [AW_W-1:0] pc;
	// Address is scrambled while no fetch is offered
	assign fetch_pc = fetch_valid ? pc : ~pc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase       <= 1'b0;
			fetch_valid <= 1'b0;
			pc          <= '0;
		end else if (!go) begin
			phase       <= 1'b0;
			fetch_valid <= 1'b0;
			pc          <= start_pc;
		end else begin
			phase       <= !phase;
			fetch_valid <= !phase;
			if (branch_valid) begin
				pc <= branch_addr;
			end else if (fetch_valid) begin
				pc <= pc + 16'h0001;
			end
		end
	end
endmodule : hlc_fetch_model
`default_nettype wire

// ===== sim/test_hardware_loop_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_hardware_loop_controller
	import hlc_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] x; logic e;} hlc_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic fetch_valid, branch_valid, rep_start = 0, rep_exec = 0, rep_hold_fetch;
	logic [15:0] fetch_pc, branch_addr, do_top = 0, do_end = 0, rword = 0, status_word;
	logic [15:0] spc = 0;
	logic [12:0] rcnt = 0, dcnt = 0;
	logic [7:0] ccv = 0;
	logic do_start = 0, loop_exit = 0, ccr_load = 0, bus_limit = 0, return_from_interrupt = 0, rts = 0;
	logic entry = 0, push_req, level0_enable, cc_select, ovf, go = 0, e;
	int fails = 0, n_compared = 0, n_end = 0, n_ovf = 0, k;
	bit seen_exit = 0;
	hlc_row_t rows [8] = '{
		'{OFS_LOOP_COUNT, 32'hffff_ffff, 32'h0000_1fff, 1'b0},
		'{OFS_LOOP_COUNT, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{OFS_LOOP_END, 32'h1234_abcd, 32'h0000_abcd, 1'b0},
		'{OFS_STATUS, 32'h0000_7c5a, 32'h0000_005a, 1'b0},
		'{OFS_STATUS, 32'h0000_0300, 32'h0000_0300, 1'b0},
		'{OFS_OPMODE, 32'h0000_ffff, 32'h0000_8100, 1'b0},
		'{OFS_OPMODE, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{8'h14, 32'h0000_5555, 32'h0000_0000, 1'b1}};
	always #10 pclk = ~pclk;
	hlc_loop_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
		.branch_valid(branch_valid), .branch_addr(branch_addr), .rep_start(rep_start),
		.rep_count(rcnt), .rep_exec(rep_exec), .rep_hold_fetch(rep_hold_fetch),
		.do_start(do_start), .do_count(dcnt), .do_top_addr(do_top), .do_end_addr(do_end),
		.loop_exit(loop_exit), .ccr_load(ccr_load), .ccr_value(ccv), .bus_limit(bus_limit),
		.rti_restore(return_from_interrupt), .rts_restore(rts), .restore_word(rword),
		.status_word(status_word), .status_push_req(push_req), .sub_or_int_entry(entry),
		.level0_enable(level0_enable), .cc_select(cc_select), .stack_overflow_irq(ovf));
	hlc_fetch_model pipe (.pclk(pclk), .presetn(presetn), .go(go), .start_pc(spc),
		.fetch_valid(fetch_valid), .fetch_pc(fetch_pc), .branch_valid(branch_valid),
		.branch_addr(branch_addr));
	always @(posedge pclk) begin
		if (ovf === 1'b1) n_ovf++;
		if (fetch_valid === 1'b1 && fetch_pc === do_end) n_end++;
		if (fetch_valid === 1'b1 && fetch_pc === do_end + 16'h0001) seen_exit = 1;
	end
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_sig(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_sig
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// Bus and loop helpers
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 0; penable <= 0;
		// Step off the edge so callers see the registers settled
		#1;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk_reg(r, x);
	endtask : rd
	task do_loop(input logic [12:0] c, input logic [15:0] t, input logic [15:0] n, input logic o);
		@(posedge pclk);
		do_start <= 1; dcnt <= c; do_top <= t; do_end <= n;
		#1 chk_sig({15'h0, ovf}, {15'h0, o});
		@(posedge pclk);
		do_start <= 0;
		@(posedge pclk);
	endtask : do_loop
	task exit_loop(input logic lf);
		@(posedge pclk); loop_exit <= 1;
		@(posedge pclk); loop_exit <= 0;
		#1 chk_sig({15'h0, status_word[SW_LF]}, {15'h0, lf});
	endtask : exit_loop
	initial begin #200us; fails++; stop_test(); end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].w);
			chk_sig({15'h0, e}, {15'h0, rows[i].e});
			apb(0, rows[i].a, 0);
			chk_reg(r, rows[i].x);
			chk_sig({15'h0, e}, {15'h0, rows[i].e});
		end
		$display("test registers done");
		apb(1, OFS_STATUS, 32'h0000_81a5);
		chk_sig(status_word, 16'h81a5);
		apb(1, OFS_LOOP_COUNT, 32'h0000_0123);
		@(posedge pclk); presetn <= 0;
		#1 chk_sig(status_word, SW_RESET);
		@(posedge pclk); presetn <= 1;
		rd(OFS_STATUS, 32'h0000_0300);
		rd(OFS_LOOP_COUNT, 32'h0000_0000);
		chk_sig({15'h0, level0_enable}, 16'h0000);
		$display("test reset done");
		apb(1, OFS_LOOP_STACK, 32'h0000_0077);
		chk_sig({15'h0, status_word[SW_LF]}, 16'h0001);
		rd(OFS_LOOP_STACK, 32'h0000_0077);
		chk_sig({15'h0, status_word[SW_LF]}, 16'h0000);
		do_loop(13'd5, 16'h0100, 16'h0110, 0);
		do_loop(13'd6, 16'h0200, 16'h0210, 0);
		rd(OFS_OPMODE, 32'h0000_8000);
		do_loop(13'd7, 16'h0300, 16'h0310, 1);
		rd(OFS_LOOP_COUNT, 32'h0000_0006);
		rd(OFS_LOOP_END, 32'h0000_0210);
		rd(OFS_LOOP_STACK, 32'h0000_0200);
		exit_loop(0);
		exit_loop(0);
		$display("test nesting done");
		do_loop(13'd3, 16'h0040, 16'h0042, 0);
		chk_sig({15'h0, status_word[SW_LF]}, 16'h0001);
		n_end = 0; seen_exit = 0; spc <= 16'h0040;
		@(posedge pclk); go <= 1;
		for (k = 0; k < 200 && !seen_exit; k++) @(posedge pclk);
		go <= 0;
		chk_sig({15'h0, seen_exit}, 16'h0001);
		chk_sig(n_end[15:0], 16'h0003);
		chk_sig({15'h0, status_word[SW_LF]}, 16'h0000);
		rd(OFS_LOOP_COUNT, 32'h0000_0001);
		$display("test loop done");
		@(posedge pclk); rep_start <= 1; rcnt <= 13'd3;
		@(posedge pclk); rep_start <= 0;
		for (int j = 0; j < 3; j++) begin
			@(posedge pclk); rep_exec <= 1;
			@(posedge pclk); rep_exec <= 0;
			#1 chk_sig({15'h0, rep_hold_fetch}, {15'h0, j < 2});
		end
		chk_sig({15'h0, status_word[SW_LF]}, 16'h0000);
		$display("test repeat done");
		@(posedge pclk); ccr_load <= 1; ccv <= 8'h25;
		@(posedge pclk); ccr_load <= 0; bus_limit <= 1;
		@(posedge pclk); bus_limit <= 0; entry <= 1;
		@(posedge pclk); entry <= 0;
		#1 chk_sig(status_word, 16'h0365);
		chk_sig({15'h0, push_req}, 16'h0001);
		@(posedge pclk); return_from_interrupt <= 1; rword <= 16'h02aa;
		@(posedge pclk); return_from_interrupt <= 0; rts <= 1; rword <= 16'h0000;
		@(posedge pclk); rts <= 0;
		#1 chk_sig(status_word, 16'h02aa);
		for (int m = 0; m < 4; m++) begin
			apb(1, OFS_STATUS, {22'h0, m[1:0], 8'h00});
			@(posedge pclk);
			chk_sig({15'h0, level0_enable}, {15'h0, m == 1});
		end
		apb(1, OFS_OPMODE, 32'h0000_0100);
		chk_sig({15'h0, cc_select}, 16'h0000);
		repeat (2) @(posedge pclk);
		chk_sig({15'h0, cc_select}, 16'h0001);
		chk_sig(n_ovf[15:0], 16'h0001);
		$display("test status done");
		stop_test();
	end
endmodule : test_hardware_loop_controller
`default_nettype wire

// ===== verilog/hlc_loop_ctrl.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hlc_loop_ctrl (
	// APB slave
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [hlc_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Fetch stage
	input  wire logic                        fetch_valid,
	input  wire logic [hlc_pkg::AW_W-1:0]    fetch_pc,
	output logic                             branch_valid,
	output logic      [hlc_pkg::AW_W-1:0]    branch_addr,
	// Decoded loop instructions
	input  wire logic                        rep_start,
	input  wire logic [hlc_pkg::LC_W-1:0]    rep_count,
	input  wire logic                        rep_exec,
	output logic                             rep_hold_fetch,
	input  wire logic                        do_start,
	input  wire logic [hlc_pkg::LC_W-1:0]    do_count,
	input  wire logic [hlc_pkg::AW_W-1:0]    do_top_addr,
	input  wire logic [hlc_pkg::AW_W-1:0]    do_end_addr,
	input  wire logic                        loop_exit,
	// Status word traffic
	input  wire logic                        ccr_load,
	input  wire logic [7:0]                  ccr_value,
	input  wire logic                        bus_limit,
	input  wire logic                        rti_restore,
	input  wire logic                        rts_restore,
	input  wire logic [15:0]                 restore_word,
	output logic      [15:0]                 status_word,
	output logic                             status_push_req,
	input  wire logic                        sub_or_int_entry,
	// Towards the interrupt and ALU units
	output logic                             level0_enable,
	output logic                             cc_select,
	output logic                             stack_overflow_irq
);
	import hlc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [LC_W-1:0] lc;
		logic [AW_W-1:0] la;
		logic            lf;
		logic            nl;
		logic [1:0]      imask;
		logic [7:0]      condition_byte;
		logic            cc_mode;
		logic            cc_eff;
		logic            rep_active;
		logic            br_valid;
		logic [AW_W-1:0] br_addr;
		logic [31:0]     rdata;
		logic            err;
		logic            push_req;
	} hlc_state_t;

	hlc_state_t st;
	hlc_state_t next_st;

	function automatic logic hlc_mapped(input logic [PADDR_W-1:0] a);
		hlc_mapped = (a == OFS_LOOP_COUNT) || (a == OFS_LOOP_END) || (a == OFS_LOOP_STACK)
			|| (a == OFS_STATUS) || (a == OFS_OPMODE);
	endfunction : hlc_mapped

	function automatic logic [15:0] hlc_sw(input hlc_state_t s);
		hlc_sw = {s.lf, 5'h00, s.imask, s.condition_byte};
	endfunction : hlc_sw

	// ----------------------------------------
	// Loop stack
	// ----------------------------------------
	logic            stk_push;
	logic            stk_pop;
	logic [AW_W-1:0] stk_data;
	logic [AW_W-1:0] stk_top;
	logic            stk_empty;
	logic            stk_full;
	logic            stk_ovf;

	hlc_loop_stack u_stack (
		.pclk      (pclk),
		.presetn   (presetn),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (stk_data),
		.top       (stk_top),
		.empty     (stk_empty),
		.full      (stk_full),
		.overflow  (stk_ovf)
	);

	// ----------------------------------------
	// Bus decode and loop end detection
	// ----------------------------------------
	logic setup_ph;
	logic acc_wr;
	logic acc_rd;
	logic loop_end;

	assign setup_ph = psel && !penable;
	assign acc_wr   = psel && penable && pwrite && hlc_mapped(paddr);
	assign acc_rd   = psel && penable && !pwrite && hlc_mapped(paddr);
	assign loop_end = st.lf && fetch_valid && (fetch_pc == st.la);

	// Stack write takes the bus, otherwise the loop start
	assign stk_push = do_start || (acc_wr && paddr == OFS_LOOP_STACK);
	assign stk_data = (acc_wr && paddr == OFS_LOOP_STACK) ? pwdata[15:0] : do_top_addr;
	assign stk_pop  = (loop_end && st.lc == LC_ONE) || loop_exit
		|| (acc_rd && paddr == OFS_LOOP_STACK);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.br_valid = 1'b0;
		next_st.push_req = sub_or_int_entry;
		// Mode change reaches the ALU one cycle after the write
		next_st.cc_eff = st.cc_mode;
		// Read data is latched in the setup cycle so prdata comes from a flop
		if (setup_ph) begin
			next_st.err = !hlc_mapped(paddr);
			next_st.rdata = 32'h0000_0000;
			unique case (paddr)
				OFS_LOOP_COUNT: next_st.rdata = {19'h00000, st.lc};
				OFS_LOOP_END:   next_st.rdata = {16'h0000, st.la};
				OFS_LOOP_STACK: next_st.rdata = {16'h0000, stk_top};
				OFS_STATUS:     next_st.rdata = {16'h0000, hlc_sw(st)};
				OFS_OPMODE:     next_st.rdata = {16'h0000, st.nl, 6'h00, st.cc_mode, 8'h00};
				default:        next_st.rdata = 32'h0000_0000;
			endcase
		end
		if (acc_wr) begin
			unique case (paddr)
				OFS_LOOP_COUNT: next_st.lc = pwdata[LC_W-1:0];
				OFS_LOOP_END:   next_st.la = pwdata[AW_W-1:0];
				OFS_LOOP_STACK: begin
					next_st.nl = st.lf;
					next_st.lf = 1'b1;
				end
				OFS_STATUS: begin
					next_st.lf = pwdata[SW_LF];
					next_st.imask = pwdata[SW_IMASK_HI:SW_IMASK_LO];
					next_st.condition_byte = pwdata[7:0];
				end
				OFS_OPMODE: begin
					next_st.nl = pwdata[OMR_NL];
					next_st.cc_mode = pwdata[OMR_CC];
				end
				default: next_st.lc = st.lc;
			endcase
		end
		if (acc_rd && paddr == OFS_LOOP_STACK) begin
			next_st.lf = st.nl;
			next_st.nl = 1'b0;
		end
		// Status word restores from the software stack
		if (rti_restore) begin
			next_st.lf = restore_word[SW_LF];
			next_st.imask = restore_word[SW_IMASK_HI:SW_IMASK_LO];
			next_st.condition_byte = restore_word[7:0];
		end else if (rts_restore) begin
			// Only extension bits move; none exist in this layout today
			next_st.condition_byte = (st.condition_byte & ~SW_PEXT_MASK[7:0]) | (restore_word[7:0] & SW_PEXT_MASK[7:0]);
		end
		if (ccr_load) begin
			next_st.condition_byte = ccr_value;
		end
		// Limiting sets the latch even against a clearing write
		if (bus_limit) begin
			next_st.condition_byte[SW_LIMIT] = 1'b1;
		end
		// Repeat never touches the active flag or the stack
		if (rep_start) begin
			next_st.lc = rep_count;
			next_st.rep_active = (rep_count != LC_RESET);
		end else if (st.rep_active && rep_exec) begin
			if (st.lc == LC_ONE || st.lc == LC_RESET) begin
				next_st.rep_active = 1'b0;
			end else begin
				next_st.lc = st.lc - LC_ONE;
			end
		end
		// Overflowing start leaves the flags as they were
		if (do_start && !stk_full) begin
			next_st.lc = do_count;
			next_st.la = do_end_addr;
			next_st.nl = st.lf;
			next_st.lf = 1'b1;
		end else if (loop_exit) begin
			next_st.lf = st.nl;
			next_st.nl = 1'b0;
		end else if (loop_end) begin
			next_st.br_valid = 1'b1;
			if (st.lc != LC_ONE) begin
				next_st.lc = st.lc - LC_ONE;
				next_st.br_addr = stk_top;
			end else begin
				next_st.lf = st.nl;
				next_st.nl = 1'b0;
				next_st.br_addr = st.la + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.imask <= IMASK_RESET;
			st.lc <= LC_RESET;
			st.la <= LA_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready             = 1'b1;
	assign prdata             = st.rdata;
	assign pslverr            = psel && penable && st.err;
	assign branch_valid       = st.br_valid;
	assign branch_addr        = st.br_addr;
	assign rep_hold_fetch     = st.rep_active;
	assign status_word        = hlc_sw(st) & SW_VALID_MASK;
	assign status_push_req    = st.push_req;
	assign level0_enable      = (st.imask == IMASK_ALL);
	assign cc_select          = st.cc_eff;
	assign stack_overflow_irq = stk_ovf;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reset_word;
		$rose(presetn) |-> status_word == SW_RESET;
	endproperty
	a_reset_word: assert property (@(posedge pclk) p_reset_word) else $error("bad reset status");
	property p_do_load;
		do_start && !stk_full && !loop_exit |=> st.lf && st.la == $past(do_end_addr) && st.nl == $past(st.lf);
	endproperty
	a_do_load: assert property (p_do_load) else $error("loop start did not load");
	property p_back_branch;
		loop_end && st.lc != LC_ONE && !do_start && !loop_exit && !rep_start
		|=> branch_valid && branch_addr == $past(stk_top) && st.lc == $past(st.lc) - LC_ONE;
	endproperty
	a_back_branch: assert property (p_back_branch) else $error("no branch to loop top");
	property p_fall_out;
		loop_end && st.lc == LC_ONE && !do_start && !loop_exit
		|=> branch_valid && branch_addr == $past(st.la) + 16'h0001 && st.lf == $past(st.nl) && !st.nl;
	endproperty
	a_fall_out: assert property (p_fall_out) else $error("bad loop exit at end");
	property p_exit;
		loop_exit && !do_start |=> st.lf == $past(st.nl) && !st.nl;
	endproperty
	a_exit: assert property (p_exit) else $error("loop exit flags wrong");
	property p_ovf_pulse;
		do_start && stk_full |-> stack_overflow_irq ##1 $stable(stk_top);
	endproperty
	a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow not signalled");
	property p_lc_read;
		setup_ph && paddr == OFS_LOOP_COUNT |=> prdata[31:LC_W] == 19'h00000;
	endproperty
	a_lc_read: assert property (p_lc_read) else $error("loop count not zero-extended");
	property p_rep_keeps_lf;
		rep_start && !do_start && !loop_exit && !loop_end && !acc_wr && !acc_rd && !rti_restore
		|=> $stable(st.lf);
	endproperty
	a_rep_keeps_lf: assert property (p_rep_keeps_lf) else $error("repeat changed active flag");
	property p_cc_delay;
		acc_wr && paddr == OFS_OPMODE |=> ##1 cc_select == $past(pwdata[OMR_CC], 2);
	endproperty
	a_cc_delay: assert property (p_cc_delay) else $error("mode change timing wrong");
	property p_mask_dec;
		acc_wr && paddr == OFS_STATUS && !rti_restore
		|=> level0_enable == ($past(pwdata[SW_IMASK_HI:SW_IMASK_LO]) == IMASK_ALL);
	endproperty
	a_mask_dec: assert property (p_mask_dec) else $error("mask decode wrong");
	// Repeat wins over a bus write to the count in the same cycle
	property p_rep_load;
		rep_start && !do_start && !loop_end
		|=> st.lc == $past(rep_count) && rep_hold_fetch == ($past(rep_count) != LC_RESET);
	endproperty
	a_rep_load: assert property (p_rep_load) else $error("repeat did not load count");
	property p_lc_write;
		acc_wr && paddr == OFS_LOOP_COUNT && !rep_start && !do_start && !loop_end
		&& !(st.rep_active && rep_exec) |=> st.lc == $past(pwdata[LC_W-1:0]);
	endproperty
	a_lc_write: assert property (p_lc_write) else $error("loop count write wrong");
	property p_limit_latch;
		bus_limit |=> status_word[SW_LIMIT];
	endproperty
	a_limit_latch: assert property (p_limit_latch) else $error("limit bit not latched");
	property p_push_req;
		sub_or_int_entry |=> status_push_req;
	endproperty
	a_push_req: assert property (p_push_req) else $error("status push not requested");
	// Entry must keep the flag, or a loop running under the handler breaks
	property p_entry_lf;
		sub_or_int_entry && !do_start && !loop_exit && !loop_end
		&& !acc_wr && !acc_rd && !rti_restore
		|=> $stable(st.lf);
	endproperty
	a_entry_lf: assert property (p_entry_lf) else $error("entry moved loop flag");

	c_back_branch: cover property (loop_end && st.lc != LC_ONE);
	c_fall_out:    cover property (loop_end && st.lc == LC_ONE);
	c_overflow:    cover property (stack_overflow_irq);
	c_rep_done:    cover property (st.rep_active ##1 !st.rep_active);
	c_stack_pop:   cover property (acc_rd && paddr == OFS_LOOP_STACK);
endmodule : hlc_loop_ctrl
`default_nettype wire

// ===== verilog/hlc_loop_stack.sv
`timescale 1ns/1ps
`default_nettype none
module hlc_loop_stack
	import hlc_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Stack operations
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [AW_W-1:0] push_data,
	// Stack state
	output logic      [AW_W-1:0] top,
	output logic                 empty,
	output logic                 full,
	output logic                 overflow
);
	typedef struct packed {
		logic [1:0][AW_W-1:0] ent;
		logic [1:0]           cnt;
	} hlc_stk_t;

	hlc_stk_t st;
	hlc_stk_t next_st;

	assign empty    = (st.cnt == 2'h0);
	assign full     = (st.cnt == 2'h2);
	assign top      = empty ? 16'h0000 : st.ent[st.cnt - 2'h1];
	assign overflow = push && full;

	always_comb begin
		next_st = st;
		if (push && !full) begin
			next_st.ent[st.cnt[0]] = push_data;
			next_st.cnt = st.cnt + 2'h1;
		end else if (pop && !empty) begin
			next_st.cnt = st.cnt - 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_full_holds;
		full && push && !pop |=> full && $stable(top);
	endproperty
	a_full_holds: assert property (p_full_holds) else $error("push on full stack changed it");
	property p_pop_empty;
		empty && pop && !push |=> empty;
	endproperty
	a_pop_empty: assert property (p_pop_empty) else $error("pop on empty stack changed it");
endmodule : hlc_loop_stack
`default_nettype wire

// ===== verilog/hlc_pkg.sv
`default_nettype none
package hlc_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int          LC_W          = 13;
	localparam int          AW_W          = 16;
	localparam int          PADDR_W       = 8;
	localparam int          STACK_DEPTH   = 2;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0]  OFS_LOOP_COUNT = 8'h00;
	localparam logic [7:0]  OFS_LOOP_END   = 8'h04;
	localparam logic [7:0]  OFS_LOOP_STACK = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0c;
	localparam logic [7:0]  OFS_OPMODE     = 8'h10;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          SW_LF          = 15;
	localparam int          SW_IMASK_HI    = 9;
	localparam int          SW_IMASK_LO    = 8;
	localparam int          SW_LIMIT       = 6;
	localparam int          OMR_NL         = 15;
	localparam int          OMR_CC         = 8;
	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [15:0] SW_RESET       = 16'h0300;
	localparam logic [15:0] SW_VALID_MASK  = 16'h83ff;
	localparam logic [15:0] SW_PEXT_MASK   = 16'h0000;
	localparam logic [1:0]  IMASK_RESET    = 2'h3;
	localparam logic [1:0]  IMASK_ALL      = 2'h1;
	localparam logic [12:0] LC_RESET       = 13'h0000;
	localparam logic [15:0] LA_RESET       = 16'h0000;
	localparam logic [12:0] LC_ONE         = 13'h0001;
endpackage : hlc_pkg
`default_nettype wire
